// ===== tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
	$display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
`define WAITHI(s) begin w = 0; while ((s) !== 1'b1 && w < 60) begin @(posedge i_clock); #1; \
	w++; end `CHK(s, 1'b1) end
module tb;
	logic        i_clock = 1'b0;
	logic        i_rst_b = 1'b0;
	logic [14:0] rc = '0;
	logic [10:0] fl = '0;
	logic [37:0] cv = '0;
	logic [3:0]  a0f = '0;
	logic        ie = 1'b1, snie = 1'b1, gie = 1'b1, uart = 1'b0, ack = 1'b0;
	logic        pw_start = 1'b0, pw_sel = 1'b0, pw_valid = 1'b0;
	logic [15:0] pw_word = '0, fa = 16'h0800;
	wire logic [15:0] mem_data;
	logic        o_mem_rd, o_pc_load, o_boot_done, o_sys_reset, o_irq, o_handler_valid;
	logic        o_bl_pw_en, o_dbg_pw_en, o_pw_ready, o_pw_done, o_pw_ok;
	logic [15:0] o_mem_addr, o_pc, o_irq_addr, o_handler;
	logic [7:0]  o_reset_cause_vector, o_serial_a0_vector, o_serial_b0_vector, o_converter_vector;
	logic [7:0]  o_system_nmi_vector, o_user_nmi_vector;
	logic [5:0]  o_dbg_pw_len;
	logic [15:0] exp_q [$];
	logic [15:0] boot_addr [4] = '{16'hff80, 16'hff82, 16'hff84, 16'hfffe};
	logic [31:0] seed = 32'ha4aa;
	logic [15:0] a;
	int          fail_count = 0, samples_checked = 0, w = 0, bi = 0, g, i, b;

	always #10 i_clock = ~i_clock;

	vts_mem_model u_mem (.i_clock, .i_rd(o_mem_rd), .i_addr(o_mem_addr), .o_data(mem_data));

	vts_vector_ctrl u_dut (
		.i_clock, .i_rst_b, .i_brownout_flag(rc[0]), .i_supply_supervisor_reset_flag(rc[1]),
		.i_pin_reset_flag(rc[2]), .i_watchdog_event_flag(rc[3] | fl[5]), .i_wdt_interval_mode(fl[5]),
		.i_wdt_ie(ie), .i_key_violation(rc[8:4]), .i_uncorrectable_bit_error_flag(rc[9]),
		.i_correctable_bit_error_flag(fl[10]), .i_segment_violation({3{rc[10]}}),
		.i_access_time_error_flag(rc[11]), .i_software_por_flag(rc[12]),
		.i_software_bor_flag(rc[13]), .i_fetch(rc[14]), .i_fetch_addr(fa),
		.i_vacant_access_flag(fl[10]), .i_debug_mailbox_in_flag(fl[10]),
		.i_debug_mailbox_out_flag(fl[10]), .i_sys_nmi_ie({6{snie}}), .i_external_nmi_flag(fl[9]),
		.i_oscillator_fault_flag(fl[9]), .i_user_nmi_ie({2{ie}}), .i_gie(gie),
		.i_comp_flags({2{fl[8]}}), .i_comp_ie({2{ie}}), .i_tb0_cc0_flag(fl[7]), .i_tb0_cc0_ie(ie),
		.i_tb0_flags({6'h00, fl[6]}), .i_tb0_ie({7{ie}}), .i_serial_a0_uart(uart),
		.i_serial_a0_flags(a0f | {3'b000, fl[4]}), .i_serial_a0_ie({4{ie}}), .i_serial_b0_i2c(uart),
		.i_serial_b0_flags({a0f, 9'h000, fl[3]}), .i_serial_b0_ie({14{ie}}),
		.i_converter_flags(cv | {37'h0, fl[2]}), .i_converter_ie({38{ie}}), .i_ta0_cc0_flag(fl[1]),
		.i_ta0_cc0_ie(ie), .i_ta0_flags({2'b00, fl[0]}), .i_ta0_ie({3{ie}}), .i_irq_ack(ack),
		.i_pw_start(pw_start), .i_pw_sel(pw_sel), .i_pw_valid(pw_valid), .i_pw_word(pw_word),
		.i_mem_data(mem_data), .o_mem_rd, .o_mem_addr, .o_pc, .o_pc_load, .o_boot_done,
		.o_sys_reset, .o_reset_cause_vector, .o_irq, .o_irq_addr, .o_handler, .o_handler_valid,
		.o_system_nmi_vector, .o_user_nmi_vector, .o_serial_a0_vector, .o_serial_b0_vector,
		.o_converter_vector, .o_bl_pw_en, .o_dbg_pw_en, .o_dbg_pw_len, .o_pw_ready, .o_pw_done,
		.o_pw_ok
	);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic pop_chk(input logic [15:0] v);
		logic [15:0] e;
		e = (exp_q.size() != 0) ? exp_q.pop_front() : ~v;
		`CHK(v, e)
	endtask

	task finish_test;
		$display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// results that appear later are matched in issue order
	always @(posedge i_clock) begin
		if (o_mem_rd === 1'b1 && o_boot_done !== 1'b1) begin
			`CHK(o_mem_addr, boot_addr[bi])
			bi = (bi + 1) % 4;
		end
		if (o_pc_load === 1'b1) pop_chk(o_pc);
		if (o_handler_valid === 1'b1) pop_chk(o_handler);
		if (o_pw_done === 1'b1) pop_chk({15'h0000, o_pw_ok});
	end

	task do_reset;
		@(posedge i_clock) i_rst_b <= 1'b0;
		repeat (16) @(posedge i_clock);
		exp_q.push_back(u_mem.mem[16'hfffe]);
		i_rst_b <= 1'b1;
		@(posedge i_clock);
		#1;
		`CHK(o_reset_cause_vector, 8'h02)
		`WAITHI(o_boot_done)
	endtask

	task rst_chk(input int n, input logic e);
		@(posedge i_clock) rc <= 15'(1) << n;
		if (e) exp_q.push_back(u_mem.mem[16'hfffe]);
		@(posedge i_clock) rc <= '0;
		#1;
		`CHK(o_sys_reset, e)
		if (e) `CHK(o_reset_cause_vector, 8'(2 * n + 4))
		if (n == 9 || n == 10) `CHK(o_system_nmi_vector, 8'(2 * n - 8))
		`WAITHI(o_boot_done)
	endtask

	task irq_chk(input logic [10:0] m, input int grp);
		@(posedge i_clock) fl <= m;
		`WAITHI(o_irq)
		`CHK(o_irq_addr, 16'hffe8 + 16'(2 * grp))
		`CHK(o_user_nmi_vector, {6'h00, m[9], 1'b0})
		`CHK(o_system_nmi_vector, {6'h00, m[10] & snie, 1'b0})
		exp_q.push_back(u_mem.mem[16'hffe8 + 16'(2 * grp)]);
		@(posedge i_clock) ack <= 1'b1;
		fl <= '0;
		@(posedge i_clock) ack <= 1'b0;
		repeat (8) @(posedge i_clock);
	endtask

	task no_irq(input logic [10:0] m);
		@(posedge i_clock) fl <= m;
		repeat (10) @(posedge i_clock);
		#1;
		`CHK(o_irq, 1'b0)
		@(posedge i_clock) fl <= '0;
		repeat (4) @(posedge i_clock);
	endtask

	task src_chk(input logic [37:0] c, input logic [3:0] f, input logic u,
			input logic [7:0] ec, input logic [7:0] ea, input logic [7:0] eb);
		@(posedge i_clock) cv <= c;
		a0f <= f;
		uart <= u;
		repeat (3) @(posedge i_clock);
		#1;
		`CHK(o_converter_vector, ec)
		`CHK(o_serial_a0_vector, ea)
		`CHK(o_serial_b0_vector, eb)
	endtask

	task pw_run(input logic s, input int n, input int bad);
		logic [15:0] base;
		int k;
		base = s ? 16'hff88 : 16'hffe0;
		exp_q.push_back({15'h0000, bad >= n});
		@(posedge i_clock) pw_sel <= s;
		pw_start <= 1'b1;
		@(posedge i_clock) pw_start <= 1'b0;
		#1;
		for (k = 0; k < n; k++) begin
			`WAITHI(o_pw_ready)
			@(posedge i_clock) pw_word <= u_mem.mem[base + 16'(2 * k)] ^ 16'(k == bad);
			pw_valid <= 1'b1;
			@(posedge i_clock) pw_valid <= 1'b0;
			#1;
		end
		repeat (8) @(posedge i_clock);
	endtask

	initial begin
		// the password range overlaps the vectors, so one random fill serves both
		for (a = 16'hff88; a != 16'h0000; a += 16'h0002) begin
			seed = lfsr(seed);
			u_mem.mem[a] = seed[15:0];
		end
		u_mem.mem[16'hff80] = 16'ha5a5;
		u_mem.mem[16'hff82] = 16'h0005;
		u_mem.mem[16'hff84] = 16'h5a5a;
		do_reset();
		`CHK(o_dbg_pw_en, 1'b1)
		`CHK(o_dbg_pw_len, 6'h05)
		`CHK(o_bl_pw_en, 1'b1)
		for (g = 0; g < 11; g++) irq_chk(11'(1) << g, g);
		for (g = 1; g < 11; g++) irq_chk(11'(3) << (g - 1), g);
		@(posedge i_clock) gie <= 1'b0;
		irq_chk(11'h7ff, 10);
		@(posedge i_clock) snie <= 1'b0;
		irq_chk(11'h7ff, 9);
		no_irq(11'h1ff);
		@(posedge i_clock) ie <= 1'b0;
		no_irq(11'h7ff);
		@(posedge i_clock) ie <= 1'b1;
		snie <= 1'b1;
		for (i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			b = seed % 38;
			src_chk((38'(1) << b) | (38'(1) << 37), 4'b1110, 1'b0, 8'(2 * b + 2), 8'h04, 8'h00);
		end
		src_chk('0, 4'b1100, 1'b1, 8'h00, 8'h06, 8'h1a);
		src_chk('0, 4'b0000, 1'b0, 8'h00, 8'h00, 8'h00);
		@(posedge i_clock) gie <= 1'b1;
		pw_run(1'b0, 16, 99);
		pw_run(1'b0, 16, 15);
		pw_run(1'b1, 5, 99);
		pw_run(1'b1, 5, 0);
		for (i = 0; i < 15; i++) rst_chk(i, 1'b1);
		@(posedge i_clock) fa <= 16'h1000;
		rst_chk(14, 1'b0);
		@(posedge i_clock) fa <= 16'h0fff;
		rst_chk(14, 1'b1);
		u_mem.mem[16'hff82] = 16'h0050;
		u_mem.mem[16'hff84] = 16'h0000;
		do_reset();
		`CHK(o_dbg_pw_len, 6'h3c)
		`CHK(o_bl_pw_en, 1'b0)
		pw_run(1'b0, 0, 99);
		`CHK(exp_q.size(), 0)
		finish_test();
	end

	initial begin
		#1000000;
		fail_count++;
		finish_test();
	end
endmodule

// ===== vts_defines.svh
`ifndef VTS_DEFINES_SVH
`define VTS_DEFINES_SVH

// memory map of the top region
`define VTS_RST_VEC      16'hfffe
`define VTS_VEC_BASE     16'hffe8
`define VTS_BL_PW_BASE   16'hffe0
`define VTS_SIG_DBG      16'hff80
`define VTS_SIG_DBG_LEN  16'hff82
`define VTS_SIG_BL       16'hff84
`define VTS_DBG_PW_BASE  16'hff88

// signature values that switch a password on, and the password lengths in words
`define VTS_DBG_PW_EN    16'ha5a5
`define VTS_BL_PW_EN     16'h5a5a
`define VTS_BL_PW_LEN    6'h10
`define VTS_DBG_PW_MAX   6'h3c

// default peripheral register space
`define VTS_PERIPH_LO    16'h0000
`define VTS_PERIPH_HI    16'h0fff

// vector groups, index i sits at VEC_BASE + 2*i
`define VTS_NUM_VEC      11
`define VTS_G_UNMI       9
`define VTS_G_SNMI       10

// reset cause vector code after power-up
`define VTS_RC_POWERUP   8'h02

`endif

// ===== vts_mem_model.sv
`timescale 1ns/1ps
// memory behind the read port; the bench preloads the top region
module vts_mem_model (
	input  wire logic        i_clock,
	input  wire logic        i_rd,
	input  wire logic [15:0] i_addr,
	output logic [15:0]      o_data
);
	logic [15:0] mem [logic [15:0]];
	logic [15:0] dat_q = 16'h0000;
	logic        drv_q = 1'b0;

	// outside the answer cycle the bus shows the inverse, so stale data never matches
	assign o_data = drv_q ? dat_q : ~dat_q;

	always @(posedge i_clock) begin
		drv_q <= i_rd;
		if (i_rd) begin
			dat_q <= mem.exists(i_addr) ? mem[i_addr] : ~i_addr;
		end
	end
endmodule

// ===== vts_pkg.sv
package vts_pkg;
	typedef enum logic [2:0] {
		VTS_BOOT_DBG_SIG,
		VTS_BOOT_DBG_LEN,
		VTS_BOOT_BL_SIG,
		VTS_BOOT_RST_VEC,
		VTS_IDLE,
		VTS_FETCH_VEC,
		VTS_PW_CMP
	} vts_state_t;
	typedef logic [15:0] vts_word_t;
endpackage

// ===== vts_prio_enc.sv
`timescale 1ns/1ps
// highest set index wins
module vts_prio_enc #(
	parameter int N = 11
) (
	input  wire logic [N-1:0]         i_req,
	output logic                      o_any,
	output logic [$clog2(N)-1:0]      o_idx
);
	always_comb begin
		o_any = |i_req;
		o_idx = '0;
		for (int i = 0; i < N; i++) begin
			if (i_req[i]) begin
				o_idx = ($clog2(N))'(i);
			end
		end
	end
endmodule

// ===== vts_src_group.sv
`timescale 1ns/1ps
// one vector's flag group: pending level and the lowest-set source code (2, 4, 6, ...)
module vts_src_group #(
	parameter int W = 1
) (
	input  wire logic [W-1:0] i_flags,
	input  wire logic [W-1:0] i_ie,
	output logic              o_pend,
	output logic [7:0]        o_iv
);
	logic [W-1:0] act;

	always_comb begin
		act = i_flags & i_ie;
		o_pend = |act;
		o_iv = 8'h00;
		for (int i = W - 1; i >= 0; i--) begin
			if (act[i]) begin
				o_iv = 8'((i + 1) * 2);
			end
		end
	end
endmodule

// ===== vts_vector_ctrl.sv
`timescale 1ns/1ps
`include "vts_defines.svh"
// What this block does
// [RL1] after reset, fetch word at 0fffe and load it as the program counter
// [RL2] interrupt vectors are 16-bit words growing down from 0fffc
// [RL3] if enabled by signature, words 0ffe0..0ffff are the boot-loader password
// [RL4] signature words from 0ff80 are read before application code starts
// [RL5] debug password from 0ff88 upward, length set by debug signature
// [RL6] supply, brownout, pin and watchdog timeout all reset via 0fffe
// [RL7] key violations, uncorrectable bit errors, segment and access faults, software resets reset
// [RL8] instruction fetch inside peripheral space causes a system reset
// [RL9] vacant access, mailbox, bit errors, segment violations raise system nmi
// [RL10] nmi vectors blocked only by own enables, not by global enable
// [RL11] watchdog interval mode requests maskable vector 0fff2
// [RL12] serial a0 requests 0fff0 with spi or uart source sets
// [RL13] serial b0 requests 0ffee with i2c or spi source sets
// [RL14] converter requests 0ffec with result, window, ready and overflow flags
// [RL15] among pending interrupts the higher vector address is served first
// [RL16] timer b0 uses 0fff6/0fff4, timer a0 uses 0ffea/0ffe8
// [RL17] external nmi and oscillator fault use 0fffa, comparator uses 0fff8
module vts_vector_ctrl #(
	parameter logic [15:0] PERIPH_LO  = `VTS_PERIPH_LO,
	parameter logic [15:0] PERIPH_HI  = `VTS_PERIPH_HI,
	parameter logic [5:0]  DBG_PW_MAX = `VTS_DBG_PW_MAX
) (
	input  wire logic        i_clock,
	input  wire logic        i_rst_b,
	input  wire logic        i_brownout_flag,
	input  wire logic        i_supply_supervisor_reset_flag,
	input  wire logic        i_pin_reset_flag,
	input  wire logic        i_watchdog_event_flag,
	input  wire logic        i_wdt_interval_mode,
	input  wire logic        i_wdt_ie,
	input  wire logic [4:0]  i_key_violation,
	input  wire logic        i_uncorrectable_bit_error_flag,
	input  wire logic        i_correctable_bit_error_flag,
	input  wire logic [2:0]  i_segment_violation,
	input  wire logic        i_access_time_error_flag,
	input  wire logic        i_software_por_flag,
	input  wire logic        i_software_bor_flag,
	input  wire logic        i_fetch,
	input  wire logic [15:0] i_fetch_addr,
	input  wire logic        i_vacant_access_flag,
	input  wire logic        i_debug_mailbox_in_flag,
	input  wire logic        i_debug_mailbox_out_flag,
	input  wire logic [5:0]  i_sys_nmi_ie,
	input  wire logic        i_external_nmi_flag,
	input  wire logic        i_oscillator_fault_flag,
	input  wire logic [1:0]  i_user_nmi_ie,
	input  wire logic        i_gie,
	input  wire logic [1:0]  i_comp_flags,
	input  wire logic [1:0]  i_comp_ie,
	input  wire logic        i_tb0_cc0_flag,
	input  wire logic        i_tb0_cc0_ie,
	input  wire logic [6:0]  i_tb0_flags,
	input  wire logic [6:0]  i_tb0_ie,
	input  wire logic        i_serial_a0_uart,
	input  wire logic [3:0]  i_serial_a0_flags,
	input  wire logic [3:0]  i_serial_a0_ie,
	input  wire logic        i_serial_b0_i2c,
	input  wire logic [13:0] i_serial_b0_flags,
	input  wire logic [13:0] i_serial_b0_ie,
	input  wire logic [37:0] i_converter_flags,
	input  wire logic [37:0] i_converter_ie,
	input  wire logic        i_ta0_cc0_flag,
	input  wire logic        i_ta0_cc0_ie,
	input  wire logic [2:0]  i_ta0_flags,
	input  wire logic [2:0]  i_ta0_ie,
	input  wire logic        i_irq_ack,
	input  wire logic        i_pw_start,
	input  wire logic        i_pw_sel,
	input  wire logic        i_pw_valid,
	input  wire logic [15:0] i_pw_word,
	input  wire logic [15:0] i_mem_data,
	output logic             o_mem_rd,
	output logic [15:0]      o_mem_addr,
	output logic [15:0]      o_pc,
	output logic             o_pc_load,
	output logic             o_boot_done,
	output logic             o_sys_reset,
	output logic [7:0]       o_reset_cause_vector,
	output logic             o_irq,
	output logic [15:0]      o_irq_addr,
	output logic [15:0]      o_handler,
	output logic             o_handler_valid,
	output logic [7:0]       o_system_nmi_vector,
	output logic [7:0]       o_user_nmi_vector,
	output logic [7:0]       o_serial_a0_vector,
	output logic [7:0]       o_serial_b0_vector,
	output logic [7:0]       o_converter_vector,
	output logic             o_bl_pw_en,
	output logic             o_dbg_pw_en,
	output logic [5:0]       o_dbg_pw_len,
	output logic             o_pw_ready,
	output logic             o_pw_done,
	output logic             o_pw_ok
);
	localparam int NV = `VTS_NUM_VEC;

	vts_pkg::vts_state_t state_q, state_d;
	logic [1:0]  pend_q, pend_d;
	logic        rd_q, rd_d, pc_load_q, pc_load_d, boot_q, boot_d;
	logic [15:0] addr_q, addr_d, pc_q, pc_d, hnd_q, hnd_d, irq_addr_q, irq_addr_d;
	logic        hnd_v_q, hnd_v_d, irq_q, irq_d, srst_q, srst_d;
	logic [3:0]  irq_idx_q, irq_idx_d;
	logic [7:0]  rc_q, rc_d, snmi_q, snmi_d, unmi_q, unmi_d;
	logic [7:0]  a0_q, a0_d, b0_q, b0_d, cnv_q, cnv_d;
	logic        bl_en_q, bl_en_d, dbg_en_q, dbg_en_d;
	logic [5:0]  dbg_len_q, dbg_len_d, idx_q, idx_d;
	logic        sel_q, sel_d, act_q, act_d, bad_q, bad_d;
	logic        rdy_q, rdy_d, done_q, done_d, ok_q, ok_d;
	logic [15:0] word_q, word_d;

	logic [15:0] rc_flags;
	logic [7:0]  rc_iv, snmi_iv, unmi_iv, a0_iv, b0_iv, cnv_iv;
	logic        rst_ev, fetch_bad, win_any, bad_now;
	logic [NV-1:0] pend, req;
	logic [3:0]  win_idx;
	logic [5:0]  sel_len, len_now;
	logic [15:0] raddr;

	// instruction fetch from peripheral registers is a system reset
	assign fetch_bad = i_fetch && (i_fetch_addr >= PERIPH_LO) && (i_fetch_addr <= PERIPH_HI); // RL8
	// bit 0 stays free for the power-up code; lower index reports first
	assign rc_flags = {fetch_bad, i_software_bor_flag, i_software_por_flag, // RL7
		i_access_time_error_flag, |i_segment_violation, i_uncorrectable_bit_error_flag,
		i_key_violation, i_watchdog_event_flag && !i_wdt_interval_mode, // RL6
		i_pin_reset_flag, i_supply_supervisor_reset_flag, i_brownout_flag, 1'b0};
	assign rst_ev = |rc_flags;

	vts_src_group #(.W(16)) u_rst (.i_flags(rc_flags), .i_ie(16'hffff),
		.o_pend(), .o_iv(rc_iv));
	vts_src_group #(.W(6)) u_snmi (.i_flags({|i_segment_violation, // RL9
		i_uncorrectable_bit_error_flag, i_correctable_bit_error_flag,
		i_debug_mailbox_out_flag, i_debug_mailbox_in_flag, i_vacant_access_flag}),
		.i_ie(i_sys_nmi_ie), .o_pend(pend[`VTS_G_SNMI]), .o_iv(snmi_iv));
	vts_src_group #(.W(2)) u_unmi (.i_flags({i_oscillator_fault_flag, i_external_nmi_flag}),
		.i_ie(i_user_nmi_ie), .o_pend(pend[`VTS_G_UNMI]), .o_iv(unmi_iv)); // RL17
	vts_src_group #(.W(2)) u_comp (.i_flags(i_comp_flags), .i_ie(i_comp_ie),
		.o_pend(pend[8]), .o_iv()); // RL17
	vts_src_group #(.W(1)) u_tb0c0 (.i_flags(i_tb0_cc0_flag), .i_ie(i_tb0_cc0_ie),
		.o_pend(pend[7]), .o_iv()); // RL16
	vts_src_group #(.W(7)) u_tb0 (.i_flags(i_tb0_flags), .i_ie(i_tb0_ie),
		.o_pend(pend[6]), .o_iv()); // RL16
	vts_src_group #(.W(1)) u_wdt (.i_flags(i_watchdog_event_flag && i_wdt_interval_mode),
		.i_ie(i_wdt_ie), .o_pend(pend[5]), .o_iv()); // RL11
	// spi mode only has the receive and transmit flags in bits 1:0
	vts_src_group #(.W(4)) u_a0 (.i_flags(i_serial_a0_flags), // RL12
		.i_ie(i_serial_a0_ie & (i_serial_a0_uart ? 4'hf : 4'h3)),
		.o_pend(pend[4]), .o_iv(a0_iv));
	vts_src_group #(.W(14)) u_b0 (.i_flags(i_serial_b0_flags), // RL13
		.i_ie(i_serial_b0_ie & (i_serial_b0_i2c ? 14'h3fff : 14'h0003)),
		.o_pend(pend[3]), .o_iv(b0_iv));
	vts_src_group #(.W(38)) u_cnv (.i_flags(i_converter_flags), .i_ie(i_converter_ie),
		.o_pend(pend[2]), .o_iv(cnv_iv)); // RL14
	vts_src_group #(.W(1)) u_ta0c0 (.i_flags(i_ta0_cc0_flag), .i_ie(i_ta0_cc0_ie),
		.o_pend(pend[1]), .o_iv()); // RL16
	vts_src_group #(.W(3)) u_ta0 (.i_flags(i_ta0_flags), .i_ie(i_ta0_ie),
		.o_pend(pend[0]), .o_iv()); // RL16

	// the global enable gates only the maskable groups
	assign req = pend & {2'b11, {(NV - 2){i_gie}}}; // RL10

	vts_prio_enc #(.N(NV)) u_prio (.i_req(req), .o_any(win_any), .o_idx(win_idx)); // RL15

	assign sel_len = sel_q ? dbg_len_q : (bl_en_q ? `VTS_BL_PW_LEN : 6'h00);
	assign len_now = i_pw_sel ? dbg_len_q : (bl_en_q ? `VTS_BL_PW_LEN : 6'h00);
	assign bad_now = bad_q || (i_mem_data != word_q);

	always_comb begin
		raddr = 16'h0000;
		unique case (state_q)
			vts_pkg::VTS_BOOT_DBG_SIG: raddr = `VTS_SIG_DBG; // RL4
			vts_pkg::VTS_BOOT_DBG_LEN: raddr = `VTS_SIG_DBG_LEN;
			vts_pkg::VTS_BOOT_BL_SIG:  raddr = `VTS_SIG_BL;
			vts_pkg::VTS_BOOT_RST_VEC: raddr = `VTS_RST_VEC; // RL1
			vts_pkg::VTS_FETCH_VEC:    raddr = `VTS_VEC_BASE + {11'h000, irq_idx_q, 1'b0}; // RL2
			vts_pkg::VTS_PW_CMP:       raddr = (sel_q ? `VTS_DBG_PW_BASE : `VTS_BL_PW_BASE) // RL3
				+ {9'h000, idx_q, 1'b0}; // RL5
			vts_pkg::VTS_IDLE:         raddr = 16'h0000;
		endcase
	end

	always_comb begin
		state_d = state_q;
		pend_d = pend_q;
		rd_d = 1'b0;
		addr_d = addr_q;
		pc_d = pc_q;
		pc_load_d = 1'b0;
		boot_d = boot_q;
		hnd_d = hnd_q;
		hnd_v_d = 1'b0;
		irq_d = 1'b0;
		irq_idx_d = irq_idx_q;
		irq_addr_d = irq_addr_q;
		srst_d = rst_ev;
		rc_d = rst_ev ? rc_iv : rc_q;
		snmi_d = snmi_iv;
		unmi_d = unmi_iv;
		a0_d = a0_iv;
		b0_d = b0_iv;
		cnv_d = cnv_iv;
		bl_en_d = bl_en_q;
		dbg_en_d = dbg_en_q;
		dbg_len_d = dbg_len_q;
		idx_d = idx_q;
		sel_d = sel_q;
		act_d = act_q;
		bad_d = bad_q;
		done_d = 1'b0;
		ok_d = ok_q;
		word_d = word_q;
		if (rst_ev) begin
			// a system reset restarts the signature walk and the reset fetch
			state_d = vts_pkg::VTS_BOOT_DBG_SIG; // RL6
			pend_d = 2'h0;
			boot_d = 1'b0;
			act_d = 1'b0;
		end else if (state_q == vts_pkg::VTS_IDLE) begin
			if (irq_q && i_irq_ack) begin
				state_d = vts_pkg::VTS_FETCH_VEC;
			end else if (i_pw_start) begin
				sel_d = i_pw_sel;
				idx_d = 6'h00;
				bad_d = 1'b0;
				act_d = len_now != 6'h00;
				done_d = len_now == 6'h00;
				ok_d = len_now == 6'h00;
			end else if (rdy_q && i_pw_valid) begin
				word_d = i_pw_word;
				state_d = vts_pkg::VTS_PW_CMP;
			end else if (boot_q && win_any) begin
				irq_d = 1'b1; // RL15
				irq_idx_d = win_idx;
				irq_addr_d = `VTS_VEC_BASE + {11'h000, win_idx, 1'b0}; // RL2
			end
		end else begin
			// memory answers the cycle after the read strobe
			unique case (pend_q)
				2'h0: begin
					rd_d = 1'b1;
					addr_d = raddr;
					pend_d = 2'h1;
				end
				2'h1: pend_d = 2'h2;
				default: begin
					pend_d = 2'h0;
					unique case (state_q)
						vts_pkg::VTS_BOOT_DBG_SIG: begin
							dbg_en_d = i_mem_data == `VTS_DBG_PW_EN; // RL5
							state_d = vts_pkg::VTS_BOOT_DBG_LEN;
						end
						vts_pkg::VTS_BOOT_DBG_LEN: begin
							// length is in words and may run into the vectors
							dbg_len_d = !dbg_en_q ? 6'h00 : (i_mem_data > 16'(DBG_PW_MAX))
								? DBG_PW_MAX : i_mem_data[5:0]; // RL5
							state_d = vts_pkg::VTS_BOOT_BL_SIG;
						end
						vts_pkg::VTS_BOOT_BL_SIG: begin
							bl_en_d = i_mem_data == `VTS_BL_PW_EN; // RL3
							state_d = vts_pkg::VTS_BOOT_RST_VEC;
						end
						vts_pkg::VTS_BOOT_RST_VEC: begin
							pc_d = i_mem_data; // RL1
							pc_load_d = 1'b1;
							boot_d = 1'b1;
							state_d = vts_pkg::VTS_IDLE;
						end
						vts_pkg::VTS_FETCH_VEC: begin
							hnd_d = i_mem_data; // RL2
							hnd_v_d = 1'b1;
							state_d = vts_pkg::VTS_IDLE;
						end
						vts_pkg::VTS_PW_CMP: begin
							bad_d = bad_now; // RL3
							idx_d = idx_q + 6'h01;
							state_d = vts_pkg::VTS_IDLE;
							if (idx_q + 6'h01 == sel_len) begin
								act_d = 1'b0;
								done_d = 1'b1;
								ok_d = !bad_now;
							end
						end
						vts_pkg::VTS_IDLE: state_d = vts_pkg::VTS_IDLE;
					endcase
				end
			endcase
		end
		rdy_d = act_d && (state_d == vts_pkg::VTS_IDLE) && !rst_ev && !i_pw_start;
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			state_q <= vts_pkg::VTS_BOOT_DBG_SIG;
			pend_q <= 2'h0;
			rd_q <= 1'b0;
			addr_q <= 16'h0000;
			pc_q <= 16'h0000;
			pc_load_q <= 1'b0;
			boot_q <= 1'b0;
			hnd_q <= 16'h0000;
			hnd_v_q <= 1'b0;
			irq_q <= 1'b0;
			irq_idx_q <= 4'h0;
			irq_addr_q <= 16'h0000;
			srst_q <= 1'b0;
			rc_q <= `VTS_RC_POWERUP;
			{snmi_q, unmi_q, a0_q, b0_q, cnv_q} <= 40'h00_0000_0000;
			{bl_en_q, dbg_en_q, sel_q, act_q, bad_q, rdy_q, done_q, ok_q} <= 8'h00;
			dbg_len_q <= 6'h00;
			idx_q <= 6'h00;
			word_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			pend_q <= pend_d;
			rd_q <= rd_d;
			addr_q <= addr_d;
			pc_q <= pc_d;
			pc_load_q <= pc_load_d;
			boot_q <= boot_d;
			hnd_q <= hnd_d;
			hnd_v_q <= hnd_v_d;
			irq_q <= irq_d;
			irq_idx_q <= irq_idx_d;
			irq_addr_q <= irq_addr_d;
			srst_q <= srst_d;
			rc_q <= rc_d;
			{snmi_q, unmi_q, a0_q, b0_q, cnv_q} <= {snmi_d, unmi_d, a0_d, b0_d, cnv_d};
			{bl_en_q, dbg_en_q, sel_q, act_q} <= {bl_en_d, dbg_en_d, sel_d, act_d};
			{bad_q, rdy_q, done_q, ok_q} <= {bad_d, rdy_d, done_d, ok_d};
			dbg_len_q <= dbg_len_d;
			idx_q <= idx_d;
			word_q <= word_d;
		end
	end

	assign o_mem_rd = rd_q;
	assign o_mem_addr = addr_q;
	assign o_pc = pc_q;
	assign o_pc_load = pc_load_q;
	assign o_boot_done = boot_q;
	assign o_sys_reset = srst_q;
	assign o_reset_cause_vector = rc_q;
	assign o_irq = irq_q;
	assign o_irq_addr = irq_addr_q;
	assign o_handler = hnd_q;
	assign o_handler_valid = hnd_v_q;
	assign o_system_nmi_vector = snmi_q;
	assign o_user_nmi_vector = unmi_q;
	assign o_serial_a0_vector = a0_q;
	assign o_serial_b0_vector = b0_q;
	assign o_converter_vector = cnv_q;
	assign o_bl_pw_en = bl_en_q;
	assign o_dbg_pw_en = dbg_en_q;
	assign o_dbg_pw_len = dbg_len_q;
	assign o_pw_ready = rdy_q;
	assign o_pw_done = done_q;
	assign o_pw_ok = ok_q;

	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);

	rst_vec_addr_a: assert property (pc_load_q |-> $past(addr_q, 2) == `VTS_RST_VEC) // RL1
		else $error("program counter not loaded from reset vector");
	vec_addr_a: assert property (irq_q |-> irq_addr_q == 16'hffe8 + 16'(irq_idx_q) * 16'h0002) // RL2
		else $error("vector address does not match group");
	bl_range_a: assert property (rd_q && state_q == vts_pkg::VTS_PW_CMP && !sel_q // RL3
		|-> addr_q >= `VTS_BL_PW_BASE) else $error("boot-loader password read out of range");
	sig_boot_a: assert property ($rose(boot_q) |-> $past(state_q) == vts_pkg::VTS_BOOT_RST_VEC // RL4
		&& !$past(boot_q)) else $error("boot completed without signature walk");
	dbg_range_a: assert property (rd_q && state_q == vts_pkg::VTS_PW_CMP && sel_q // RL5
		|-> addr_q >= `VTS_DBG_PW_BASE) else $error("debug password read below base");
	pin_reset_a: assert property (i_pin_reset_flag |=> srst_q ##1 // RL6
		(state_q != vts_pkg::VTS_IDLE)) else $error("pin reset not restarting");
	key_reset_a: assert property ((|i_key_violation) |=> srst_q && !boot_q) // RL7
		else $error("key violation missed reset");
	fetch_reset_a: assert property (fetch_bad |=> srst_q && rc_q == 8'h20) // RL8
		else $error("peripheral fetch missed reset");
	nmi_gie_a: assert property (irq_q && !$past(i_gie) |-> irq_idx_q >= 4'h9) // RL10
		else $error("maskable request taken with global enable off");
	prio_a: assert property (irq_q |-> ($past(req) >> irq_idx_q) == 11'h001) // RL15
		else $error("lower vector served before higher");
endmodule
